// ---- inc/parallel_output_consts.svh ----
// constants for the parallel output port: offsets, fields, reset values, timing
`ifndef PARALLEL_OUTPUT_CONSTS_SVH
`define PARALLEL_OUTPUT_CONSTS_SVH
// ====================================================
// register offsets (word select values, compared with bus_addr[2:1])
`define PO_ADDR_W 3
`define PO_OFS_CTRL 2'h0
`define PO_OFS_WORD 2'h1
`define PO_OFS_IN 2'h2
// register select bits and byte lane within the word
`define PO_SEL_HI 2
`define PO_SEL_LO 1
`define PO_BYTE_HI 0
`define PO_LANE_W 8
// ====================================================
// control word fields
`define PO_CTRL_UC0 0
`define PO_CTRL_UC1 1
`define PO_CTRL_IEB 5
`define PO_CTRL_IEA 6
`define PO_CTRL_RESET 16'h0000
`define PO_CTRL_MASK 16'h0063
`define PO_WORD_RESET 16'h0000
// ====================================================
// timing and buffer depth
`define PO_CLK_NS 4
`define PO_STROBE_NS 750
`define PO_FIFO_DEPTH 8
`endif

// ---- inc/parallel_output_pkg.sv ----
// types shared by the parallel output port
package parallel_output_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_LOAD = 2'b01,
        SEQ_SETUP = 2'b10,
        SEQ_PULSE = 2'b11
    } seq_state_t;
endpackage

// ---- inc/word_fifo_if.sv ----
// carrier between the bus side and the word buffer
`timescale 1ns/100ps
interface word_fifo_if #(parameter int WIDTH = 16);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    modport store (input push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
endinterface

// ---- src/parallel_output_port.sv ----
// output half of a 16-bit parallel line interface with written strobe
`timescale 1ns/100ps
`include "parallel_output_consts.svh"
module parallel_output_port #(
    parameter int DATA_W = 16,
    parameter int STROBE_NS = `PO_STROBE_NS,
    parameter int FIFO_DEPTH = `PO_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // system bus register port
    input wire logic bus_initialize,
    input wire logic [`PO_ADDR_W-1:0] bus_addr,
    input wire logic bus_write,
    input wire logic bus_byte,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_read,
    output logic [DATA_W-1:0] bus_rdata,
    output logic bus_ready,
    // user device lines
    output logic [DATA_W-1:0] out_line,
    output logic new_data_strobe,
    output logic user_control_bit0,
    output logic user_control_bit1,
    output logic init_out_conn1,
    output logic init_out_conn2
);
    localparam int STROBE_CYCLES = (STROBE_NS + `PO_CLK_NS - 1) / `PO_CLK_NS;
    localparam int CW = $clog2(STROBE_CYCLES + 1);
    localparam logic [CW-1:0] STROBE_C = CW'(STROBE_CYCLES);

    parallel_output_pkg::seq_state_t state_reg, state_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [DATA_W-1:0] parallel_output_word_reg, parallel_output_word_next;
    logic [DATA_W-1:0] shadow_reg, shadow_next;
    logic [DATA_W-1:0] ctrl_reg, ctrl_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic strobe_reg, strobe_next;
    logic init_reg;
    logic ready_reg;
    logic [DATA_W-1:0] merged;
    logic [1:0] sel;
    logic wr_word, wr_ctrl;

    word_fifo_if #(.WIDTH(DATA_W)) fq ();

    word_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .flush(bus_initialize),
        .port(fq.store)
    );

    // ====================================================
    // bus decode; word writes refused while the buffer is full
    assign sel = bus_addr[`PO_SEL_HI:`PO_SEL_LO];
    assign wr_word = bus_write && (sel == `PO_OFS_WORD) && fq.push_ready && !bus_initialize;
    assign wr_ctrl = bus_write && (sel == `PO_OFS_CTRL) && !bus_initialize;

    // byte writes merge into the last written word, odd address is high byte
    always_comb
    begin
        merged = bus_wdata;
        if (bus_byte && bus_addr[`PO_BYTE_HI])
            merged = {bus_wdata[DATA_W-1:`PO_LANE_W], shadow_reg[`PO_LANE_W-1:0]};
        else if (bus_byte)
            merged = {shadow_reg[DATA_W-1:`PO_LANE_W], bus_wdata[`PO_LANE_W-1:0]};
    end

    assign fq.push_valid = wr_word;
    assign fq.push_data = merged;
    assign fq.pop_ready = (state_reg == parallel_output_pkg::SEQ_IDLE) && !bus_initialize;

    // ====================================================
    // register file next values
    always_comb
    begin
        shadow_next = shadow_reg;
        ctrl_next = ctrl_reg;
        rdata_next = rdata_reg;
        if (bus_initialize)
        begin
            shadow_next = `PO_WORD_RESET;
            ctrl_next = `PO_CTRL_RESET;
        end
        else
        begin
            if (wr_word)
                shadow_next = merged;
            if (wr_ctrl)
                ctrl_next = bus_wdata & `PO_CTRL_MASK;
        end
        if (bus_read)
        begin
            unique case (sel)
                `PO_OFS_CTRL: rdata_next = ctrl_reg;
                `PO_OFS_WORD: rdata_next = shadow_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    // ====================================================
    // strobe sequencer: pop, load the lines, then raise the strobe
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        parallel_output_word_next = parallel_output_word_reg;
        unique case (state_reg)
            parallel_output_pkg::SEQ_IDLE:
                if (fq.pop_valid)
                    state_next = parallel_output_pkg::SEQ_LOAD;
            parallel_output_pkg::SEQ_LOAD:
            begin
                parallel_output_word_next = fq.pop_data;
                state_next = parallel_output_pkg::SEQ_SETUP;
            end
            parallel_output_pkg::SEQ_SETUP:
            begin
                cnt_next = STROBE_C;
                state_next = parallel_output_pkg::SEQ_PULSE;
            end
            parallel_output_pkg::SEQ_PULSE:
            begin
                cnt_next = cnt_reg - 1'b1;
                if (cnt_reg == CW'(1))
                    state_next = parallel_output_pkg::SEQ_IDLE;
            end
        endcase
        if (bus_initialize)
        begin
            state_next = parallel_output_pkg::SEQ_IDLE;
            cnt_next = '0;
            parallel_output_word_next = `PO_WORD_RESET;
        end
        strobe_next = (state_next == parallel_output_pkg::SEQ_PULSE);
    end

    // ====================================================
    // all registers of the port except the check helper hi_cnt
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= parallel_output_pkg::SEQ_IDLE;
            cnt_reg <= '0;
            parallel_output_word_reg <= `PO_WORD_RESET;
            shadow_reg <= `PO_WORD_RESET;
            ctrl_reg <= `PO_CTRL_RESET;
            rdata_reg <= '0;
            strobe_reg <= 1'b0;
            init_reg <= 1'b0;
            ready_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            parallel_output_word_reg <= parallel_output_word_next;
            shadow_reg <= shadow_next;
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
            strobe_reg <= strobe_next;
            init_reg <= bus_initialize;
            ready_reg <= fq.push_ready;
        end
    end

    // outputs straight from flip-flops
    assign out_line = parallel_output_word_reg;
    assign new_data_strobe = strobe_reg;
    assign user_control_bit0 = ctrl_reg[`PO_CTRL_UC0];
    assign user_control_bit1 = ctrl_reg[`PO_CTRL_UC1];
    assign init_out_conn1 = init_reg;
    assign init_out_conn2 = init_reg;
    assign bus_rdata = rdata_reg;
    assign bus_ready = ready_reg;

    // ====================================================
    // checks; helper counts strobe high cycles
    logic [CW:0] hi_cnt;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hi_cnt <= '0;
        else
            hi_cnt <= strobe_reg ? hi_cnt + 1'b1 : '0;
    end

    property p_readback;
        @(posedge clk) disable iff (rst)
        (wr_word && !bus_byte) ##1 (!bus_write && !bus_initialize)
        ##1 (bus_read && sel == `PO_OFS_WORD && !bus_write)
        |=> bus_rdata == $past(bus_wdata, 3);
    endproperty
    a_readback: assert property (p_readback) else $error("word readback wrong");

    property p_pulse_after_write;
        @(posedge clk) disable iff (rst)
        (wr_word && state_reg == parallel_output_pkg::SEQ_IDLE && !fq.pop_valid)
        ##1 !bus_initialize [*4] |-> $rose(strobe_reg);
    endproperty
    a_pulse_after_write: assert property (p_pulse_after_write) else $error("no strobe");

    property p_width;
        @(posedge clk) disable iff (rst)
        $fell(strobe_reg) && !$past(bus_initialize) |-> hi_cnt == (CW+1)'(STROBE_CYCLES);
    endproperty
    a_width: assert property (p_width) else $error("strobe width wrong");

    property p_init_clear;
        @(posedge clk) disable iff (rst)
        bus_initialize |=> out_line == '0 && !new_data_strobe && ctrl_reg == '0;
    endproperty
    a_init_clear: assert property (p_init_clear) else $error("init did not clear");

    property p_init_bits;
        @(posedge clk) disable iff (rst)
        bus_initialize |=> !user_control_bit0 && !user_control_bit1
            && !ctrl_reg[`PO_CTRL_IEA] && !ctrl_reg[`PO_CTRL_IEB];
    endproperty
    a_init_bits: assert property (p_init_bits) else $error("control bits kept");

    property p_init_out;
        @(posedge clk) disable iff (rst)
        ##1 (init_out_conn1 == $past(bus_initialize) && init_out_conn2 == init_out_conn1);
    endproperty
    a_init_out: assert property (p_init_out) else $error("init output wrong");

    property p_lines_change;
        @(posedge clk) disable iff (rst)
        $changed(out_line) |-> $past(state_reg) == parallel_output_pkg::SEQ_LOAD
            || $past(bus_initialize);
    endproperty
    a_lines_change: assert property (p_lines_change) else $error("lines moved");

    property p_stable;
        @(posedge clk) disable iff (rst)
        strobe_reg |-> $stable(out_line);
    endproperty
    a_stable: assert property (p_stable) else $error("data moved at strobe");

    property p_ctrl;
        @(posedge clk) disable iff (rst)
        wr_ctrl |=> user_control_bit0 == $past(bus_wdata[0])
            && user_control_bit1 == $past(bus_wdata[1]);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control line wrong");
endmodule // parallel_output_port

// ---- src/word_fifo.sv ----
// word buffer with registered read data, valid and ready on both sides
`timescale 1ns/100ps
`include "parallel_output_consts.svh"
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = `PO_FIFO_DEPTH
) (
    // clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    // buffer ports
    word_fifo_if.store port
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_C = (PW)'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [PW:0] count_reg, count_next;
    logic [WIDTH-1:0] rdata_reg, rdata_next;
    logic do_push, do_pop;

    // honest full and empty straight from the fill count
    assign port.push_ready = (count_reg != DEPTH_C);
    assign port.pop_valid = (count_reg != '0);
    assign port.pop_data = rdata_reg;
    assign do_push = port.push_valid && port.push_ready;
    assign do_pop = port.pop_ready && port.pop_valid;

    // ====================================================
    // storage array, written on accepted pushes
    always_ff @(posedge clk)
    begin
        if (do_push)
            mem[wr_ptr_reg] <= port.push_data;
    end

    // ====================================================
    // pointer, count and read data next values
    always_comb
    begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        rdata_next = rdata_reg;
        if (flush)
        begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
            count_next = '0;
        end
        else
        begin
            if (do_push)
                wr_ptr_next = (wr_ptr_reg == LAST_C) ? '0 : wr_ptr_reg + 1'b1;
            if (do_pop)
            begin
                rdata_next = mem[rd_ptr_reg]; // data valid the cycle after a pop
                rd_ptr_next = (rd_ptr_reg == LAST_C) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (do_push && !do_pop)
                count_next = count_reg + 1'b1;
            else if (do_pop && !do_push)
                count_next = count_reg - 1'b1;
        end
    end

    // registers of the buffer
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            rdata_reg <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            rdata_reg <= rdata_next;
        end
    end
endmodule // word_fifo

// ---- tb/parallel_output_port_tb.sv ----
// self-checking testbench for the parallel output port
`timescale 1ns/100ps
module parallel_output_port_tb;
    // ====================================================
    // signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic bus_initialize = 1'b0;
    logic [2:0] bus_addr = 3'h0;
    logic bus_write = 1'b0;
    logic bus_byte = 1'b0;
    logic [15:0] bus_wdata = 16'h0000;
    logic bus_read = 1'b0;
    logic [15:0] bus_rdata;
    logic bus_ready;
    logic [15:0] out_line;
    logic new_data_strobe;
    logic user_control_bit0;
    logic user_control_bit1;
    logic init_out_conn1;
    logic init_out_conn2;
    logic [15:0] captured;
    logic [15:0] log_words [0:63];
    int n_captured;
    int last_width;
    int n_errors = 0;
    int comparisons = 0;
    int n_sent;
    int k;

    // clock at 250 MHz
    always #2 clk = ~clk;

    // ====================================================
    // design and user device; short strobe of 20 ns gives 5 cycles
    parallel_output_port #(.STROBE_NS(20)) dut (
        .clk(clk), .rst(rst), .bus_initialize(bus_initialize), .bus_addr(bus_addr),
        .bus_write(bus_write), .bus_byte(bus_byte), .bus_wdata(bus_wdata),
        .bus_read(bus_read), .bus_rdata(bus_rdata), .bus_ready(bus_ready),
        .out_line(out_line), .new_data_strobe(new_data_strobe),
        .user_control_bit0(user_control_bit0), .user_control_bit1(user_control_bit1),
        .init_out_conn1(init_out_conn1), .init_out_conn2(init_out_conn2));
    user_device_model partner (
        .clk(clk), .rst(rst), .out_line(out_line), .new_data_strobe(new_data_strobe),
        .init_in(init_out_conn1), .captured(captured), .n_captured(n_captured),
        .last_width(last_width), .log_words(log_words));

    // ====================================================
    // tasks
    task give_verdict();
        if (n_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [2:0] a, input logic [15:0] d, input logic b);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_byte <= b;
        bus_write <= 1'b1;
        @(posedge clk);
        bus_write <= 1'b0;
        bus_byte <= 1'b0;
    endtask

    task rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge clk);
        bus_read <= 1'b0;
        @(posedge clk);
        #1;
        check(bus_rdata, exp);
    endtask

    // bounded waits: strobe high, or a number of captured words
    task wait_for(input int n, input logic want_strobe);
        int i;
        i = 0;
        while (i < 2000 && (want_strobe ? new_data_strobe !== 1'b1 : n_captured < n))
        begin
            @(posedge clk);
            #1;
            i++;
        end
        if (i == 2000)
        begin
            n_errors++;
            give_verdict();
        end
    endtask

    // ====================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(3'h0, 16'h0000);
        rd(3'h2, 16'h0000);
        check(out_line, 16'h0000);
        // full word write, strobe, capture and readback
        wr(3'h2, 16'ha5c3, 1'b0);
        wait_for(0, 1'b1);
        check(out_line, 16'ha5c3);
        wait_for(1, 1'b0);
        check(captured, 16'ha5c3);
        check(16'(last_width), 16'h0005);
        rd(3'h2, 16'ha5c3);
        // byte writes to each lane, one strobe each
        wr(3'h3, 16'h7e7e, 1'b1);
        wait_for(2, 1'b0);
        check(captured, 16'h7ec3);
        wr(3'h2, 16'h1919, 1'b1);
        wait_for(3, 1'b0);
        check(captured, 16'h7e19);
        repeat (20) @(posedge clk);
        check(16'(n_captured), 16'h0003);
        // fill the buffer until refused, then drain in order
        n_sent = 0;
        k = 0;
        while (bus_ready === 1'b1 && k < 40)
        begin
            wr(3'h2, 16'h1000 + 16'(n_sent), 1'b0);
            n_sent++;
            k++;
            repeat (2) @(posedge clk);
            #1;
        end
        check({15'h0000, bus_ready}, 16'h0000);
        wr(3'h2, 16'hdead, 1'b0);
        wait_for(3 + n_sent, 1'b0);
        repeat (30) @(posedge clk);
        check(16'(n_captured), 16'(3 + n_sent));
        for (int i = 0; i < n_sent; i++)
            check(log_words[3 + i], 16'h1000 + 16'(i));
        rd(3'h2, 16'h1000 + 16'(n_sent - 1));
        // control bits drive the user control lines
        wr(3'h0, 16'hffff, 1'b0);
        rd(3'h0, 16'h0063);
        check({14'h0000, user_control_bit1, user_control_bit0}, 16'h0003);
        // initialize in the middle of a strobe
        wr(3'h2, 16'h5a5a, 1'b0);
        rd(3'h2, 16'h5a5a);
        wait_for(0, 1'b1);
        @(posedge clk);
        bus_initialize <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(out_line, 16'h0000);
        check({14'h0000, user_control_bit1, user_control_bit0}, 16'h0000);
        check({14'h0000, init_out_conn2, init_out_conn1}, 16'h0003);
        @(posedge clk);
        bus_initialize <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check({14'h0000, init_out_conn2, init_out_conn1}, 16'h0000);
        rd(3'h0, 16'h0000);
        rd(3'h2, 16'h0000);
        give_verdict();
    end
endmodule // parallel_output_port_tb

// ---- tb/user_device_model.sv ----
// user device model that takes in each output word on the strobe's falling edge
`timescale 1ns/100ps
module user_device_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // lines from the port
    input wire logic [15:0] out_line,
    input wire logic new_data_strobe,
    input wire logic init_in,
    // what the device has taken in
    output logic [15:0] captured,
    output int n_captured,
    output int last_width,
    output logic [15:0] log_words [0:63]
);
    // ====================================================
    // capture logic
    logic strobe_reg;
    int width_reg;

    // latch the word on the trailing edge, so the cable has settled
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            strobe_reg <= 1'b0;
            width_reg <= 0;
            captured <= 16'h0000;
            n_captured <= 0;
            last_width <= 0;
        end
        else
        begin
            strobe_reg <= new_data_strobe;
            if (new_data_strobe)
            begin
                width_reg <= width_reg + 1; // length of the pulse in cycles
            end
            if (strobe_reg && !new_data_strobe)
            begin
                captured <= out_line;
                log_words[n_captured[5:0]] <= out_line;
                n_captured <= n_captured + 1;
                last_width <= width_reg;
                width_reg <= 0;
            end
            if (init_in)
            begin
                captured <= 16'h0000; // device clears its captured word on initialize
            end
        end
    end
endmodule // user_device_model
